// *** fp_panel_regs.svh ***
`ifndef FP_PANEL_REGS_SVH
`define FP_PANEL_REGS_SVH
// ----------------------------------------------------------------------
// apb register map (byte addresses)
// ----------------------------------------------------------------------
`define FP_REG_STAT     8'h00
`define FP_REG_SET      8'h04
`define FP_REG_CTRL     8'h08
// status word fields
`define FP_ST_REMOTE    0
`define FP_ST_SAVER     1
`define FP_ST_EDIT      2
`define FP_ST_ALARM     3
`define FP_ST_LIMIT     4
`define FP_ST_HREJ      5
`define FP_ST_BUILD     6
// settings word fields
`define FP_SET_ADDR     0
`define FP_SET_BAUD     8
`define FP_SET_PAR      12
`define FP_SET_BUS      16
`define FP_SET_SRQ      17
// control word fields (write only)
`define FP_CT_GOREM     0
`define FP_CT_GOLOC     1
// ----------------------------------------------------------------------
// keypad codes
// ----------------------------------------------------------------------
`define FP_KEY_SETUP    4'h4
`define FP_KEY_SOFT_A   4'h5
`define FP_KEY_SOFT_E   4'h9
`define FP_KEY_COMMIT   4'hA
`define FP_KEY_CLEAR    4'hB
`define FP_KEY_DIGIT    4'hC
`define FP_KEY_REMOTE   4'hD
`define FP_SOFT_B       3'h1
`define FP_SOFT_C       3'h2
`define FP_SOFT_D       3'h3
`define FP_SOFT_E       3'h4
// ----------------------------------------------------------------------
// value limits and reset values
// ----------------------------------------------------------------------
`define FP_SER_ADDR_LO  8'h40
`define FP_SER_ADDR_HI  8'h5F
`define FP_GPIB_ADDR_HI 8'h1F
`define FP_ADDR_MAX     8'h7F
`define FP_BAUD_LAST    3'h6
`define FP_PAR_LAST     2'h2
`define FP_RST_ADDR     8'h40
`define FP_RST_BAUD     3'h5
`define FP_RST_PAR      2'h2
`define FP_DEC_BASE     8'h0A
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FP_CLK_NS       20
`define FP_TICK_NS      1_000_000
`define FP_IDLE_MIN     5
`define FP_ENTRY_S      10
`define FP_BEEP_MS      50
`define FP_ERR_MS       300
`endif

// *** fp_pkg.sv ***
package fp_pkg;
  // remote bus fitted at build time
  typedef enum logic [1:0] {
    BUILD_SERIAL = 2'h0,
    BUILD_RS232  = 2'h1,
    BUILD_GPIB   = 2'h2
  } build_t;
  // displayed screen, one hot
  typedef enum logic [5:0] {
    SCR_LOG   = 6'b00_0001,
    SCR_HIST  = 6'b00_0010,
    SCR_LEVEL = 6'b00_0100,
    SCR_STAT  = 6'b00_1000,
    SCR_SETUP = 6'b01_0000,
    SCR_RSUB  = 6'b10_0000
  } screen_t;
  // field under edit, one hot
  typedef enum logic [4:0] {
    F_IDLE = 5'b0_0001,
    F_BUS  = 5'b0_0010,
    F_ADDR = 5'b0_0100,
    F_BAUD = 5'b0_1000,
    F_PAR  = 5'b1_0000
  } edit_t;
endpackage : fp_pkg

// *** fp_idle_timer.sv ***
`timescale 1ns/10ps
// tick counter that saturates at LIMIT and reports it
module fp_idle_timer #(
  parameter int LIMIT = 10
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // control
  input  wire logic tick_i,
  input  wire logic restart_i,
  input  wire logic run_i,
  // status
  output logic      done_o
);
  localparam int W = $clog2(LIMIT + 1);
  logic [W-1:0] cnt_r;

  // restart wins over counting so a fresh key always gives a full period
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else if (restart_i) begin
      cnt_r <= '0;
    end else if (run_i && tick_i && !done_o) begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  assign done_o = (cnt_r == W'(LIMIT));
endmodule : fp_idle_timer

// *** fp_tone.sv ***
`timescale 1ns/10ps
// beeper driver: short acknowledge beep or longer error tone
module fp_tone #(
  parameter int ACK_T = 50,
  parameter int ERR_T = 300
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // events
  input  wire logic tick_i,
  input  wire logic ack_i,
  input  wire logic err_i,
  // sounders
  output logic      beep_o,
  output logic      err_tone_o
);
  localparam int W = $clog2(ERR_T + ACK_T + 1);
  logic [W-1:0] cnt_r;

  // error preempts a running beep; a beep never cuts an error tone short
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r      <= '0;
      beep_o     <= 1'b0;
      err_tone_o <= 1'b0;
    end else if (err_i) begin
      cnt_r      <= W'(ERR_T);
      beep_o     <= 1'b0;
      err_tone_o <= 1'b1;
    end else if (ack_i && (!err_tone_o || cnt_r == '0)) begin
      // a key landing just as the error tone runs out still gets its beep
      cnt_r      <= W'(ACK_T);
      beep_o     <= 1'b1;
      err_tone_o <= 1'b0;
    end else if (cnt_r == '0) begin
      beep_o     <= 1'b0;
      err_tone_o <= 1'b0;
    end else if (tick_i) begin
      cnt_r      <= cnt_r - W'(1);
    end
  end
endmodule : fp_tone

// *** front_panel_remote_control.sv ***
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`include "fp_panel_regs.svh"
module front_panel_remote_control
  import fp_pkg::*;
#(
  parameter int TICK_CYC = `FP_TICK_NS / `FP_CLK_NS,
  parameter int IDLE_T   = `FP_IDLE_MIN * 60 * 1000,
  parameter int ENTRY_T  = `FP_ENTRY_S * 1000
) (
  // clock and reset
  input  wire logic            mclk_i,
  input  wire logic            rst_n_i,
  // build strap
  input  wire fp_pkg::build_t  bus_build_i,
  // keypad and knob
  input  wire logic            key_press_i,
  input  wire logic [3:0]      key_code_i,
  input  wire logic [3:0]      key_digit_i,
  input  wire logic            knob_step_i,
  input  wire logic            knob_up_i,
  input  wire logic [4:0]      soft_map_i,
  // unit state
  input  wire logic [1:0]      rcvr_active_i,
  input  wire logic [9:0]      chan_manual_i,
  input  wire logic [9:0]      chan_limit_i,
  input  wire logic [3:0]      hw_fault_i,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  // panel outputs
  output fp_pkg::screen_t      screen_o,
  output logic                 saver_o,
  output logic                 remote_led_o,
  output logic                 alarm_led_o,
  output logic                 correction_limit_indicator_o,
  output logic                 beep_o,
  output logic                 err_tone_o,
  output logic [7:0]           remote_addr_o,
  output logic [2:0]           baud_sel_o,
  output logic [1:0]           parity_o,
  output logic                 bus_sel_o,
  output logic                 srq_en_o
);
  localparam int PW = $clog2(TICK_CYC);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [PW-1:0] pre_r;
  logic          tick_r, remote_r, saver_r, hrej_r, ack_r, err_r;
  logic          alarm_r, limit_r, bus_r, srq_r;
  logic [7:0]    addr_r, pend_r, pend_nxt;
  logic [2:0]    baud_r;
  logic [1:0]    par_r;
  screen_t       scr_r, scr_nxt;
  edit_t         field_r, field_nxt;
  logic          store, bad, rem_nxt, restart_e, ent_exp, idle_exp;
  logic          gpib, rs232, act, wake, saver_ok, rd_ok;
  logic [2:0]    soft_n;
  logic [31:0]   stat_w, set_w, rd_w;
  logic          apb_wr, apb_su, h_set, h_rem, h_loc, h_ok;

  assign gpib  = (bus_build_i == BUILD_GPIB);
  assign rs232 = (bus_build_i == BUILD_RS232);
  // the wake-up key is swallowed so a blind press cannot change anything
  assign wake  = key_press_i && saver_r;
  assign act   = key_press_i && !saver_r;
  assign soft_n = 3'(key_code_i - `FP_KEY_SOFT_A);

  // address window depends on the fitted bus
  function automatic logic addr_ok(input logic [7:0] a, input logic g);
    addr_ok = g ? (a <= `FP_GPIB_ADDR_HI)
                : (a >= `FP_SER_ADDR_LO && a <= `FP_SER_ADDR_HI);
  endfunction : addr_ok

  // stored value of a field, used to restore an entry on the clear key
  function automatic logic [7:0] cur_val(input edit_t f);
    case (f)
      F_BUS:   cur_val = {7'h00, gpib ? srq_r : bus_r};
      F_ADDR:  cur_val = addr_r;
      F_BAUD:  cur_val = {5'h00, baud_r};
      F_PAR:   cur_val = {6'h00, par_r};
      default: cur_val = 8'h00;
    endcase
  endfunction : cur_val

  // ----------------------------------------------------------------------
  // common tick: one prescaler feeds every timer
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_r  <= '0;
      tick_r <= 1'b0;
    end else if (pre_r == PW'(TICK_CYC - 1)) begin
      pre_r  <= '0;
      tick_r <= 1'b1;
    end else begin
      pre_r  <= pre_r + PW'(1);
      tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // keypad decode and entry machine
  // ----------------------------------------------------------------------
  always_comb begin
    scr_nxt   = scr_r;
    field_nxt = field_r;
    pend_nxt  = pend_r;
    store     = 1'b0;
    bad       = 1'b0;
    restart_e = (field_r == F_IDLE);
    rem_nxt   = h_loc ? 1'b0 : (h_rem ? 1'b1 : remote_r);
    if (act) begin
      if (key_code_i <= `FP_KEY_SETUP) begin
        scr_nxt   = screen_t'(6'h01 << key_code_i);
        field_nxt = F_IDLE;
      end else if (key_code_i == `FP_KEY_REMOTE) begin
        rem_nxt   = gpib ? 1'b0 : !remote_r;
        field_nxt = F_IDLE;
      end else if (key_code_i <= `FP_KEY_SOFT_E) begin
        case (scr_r)
          SCR_SETUP: begin
            if (soft_n == `FP_SOFT_E) begin
              scr_nxt = SCR_RSUB;
            end else if (!soft_map_i[soft_n]) begin
              bad = 1'b1;
            end
          end
          SCR_RSUB: begin
            restart_e = 1'b1;
            if (soft_n == 3'h0 || remote_r) begin
              bad = 1'b1;
            end else if (soft_n == `FP_SOFT_B) begin
              if (rs232) begin
                bad = 1'b1;
              end else if (gpib) begin
                field_nxt = F_BUS;
                pend_nxt  = {7'h00, (field_r == F_BUS) ? !pend_r[0] : !srq_r};
              end else begin
                field_nxt = F_BUS;
                pend_nxt  = {7'h00, bus_r};
              end
            end else if (soft_n == `FP_SOFT_C) begin
              field_nxt = F_ADDR;
              pend_nxt  = addr_r;
            end else if (gpib) begin
              bad = 1'b1;
            end else if (soft_n == `FP_SOFT_D) begin
              field_nxt = F_BAUD;
              pend_nxt  = {5'h00, baud_r};
            end else begin
              field_nxt = F_PAR;
              pend_nxt  = {6'h00, par_r};
            end
          end
          default: begin
            if (!soft_map_i[soft_n]) begin
              bad = 1'b1;
            end
          end
        endcase
      end else if (remote_r) begin
        bad       = 1'b1;
        field_nxt = F_IDLE;
      end else if (key_code_i == `FP_KEY_COMMIT) begin
        field_nxt = F_IDLE;
        if (field_r == F_ADDR && !addr_ok(pend_r, gpib)) begin
          bad = 1'b1;
        end else begin
          store = (field_r != F_IDLE);
        end
      end else if (key_code_i == `FP_KEY_CLEAR) begin
        pend_nxt  = cur_val(field_r);
        restart_e = 1'b1;
      end else if (key_code_i == `FP_KEY_DIGIT && field_r == F_ADDR) begin
        // a digit typed onto a value above 12 saturates it at 7F so it fails the range check
        pend_nxt = (pend_r > 8'h0C) ? `FP_ADDR_MAX
                 : 8'(pend_r * `FP_DEC_BASE + {4'h0, key_digit_i});
      end else begin
        bad = 1'b1;
      end
    end else if (knob_step_i && !saver_r && field_r != F_IDLE) begin
      if (remote_r) begin
        bad = 1'b1;
      end else begin
        case (field_r)
          F_BUS:   pend_nxt = {7'h00, !pend_r[0]};
          F_ADDR:  pend_nxt = knob_up_i ? pend_r + 8'h01 : pend_r - 8'h01;
          F_BAUD:  pend_nxt = knob_up_i
                 ? ((pend_r[2:0] == `FP_BAUD_LAST) ? 8'h00 : pend_r + 8'h01)
                 : ((pend_r == 8'h00) ? {5'h00, `FP_BAUD_LAST} : pend_r - 8'h01);
          F_PAR:   pend_nxt = knob_up_i
                 ? ((pend_r[1:0] == `FP_PAR_LAST) ? 8'h00 : pend_r + 8'h01)
                 : ((pend_r == 8'h00) ? {6'h00, `FP_PAR_LAST} : pend_r - 8'h01);
          default: pend_nxt = pend_r;
        endcase
      end
    end
    if (ent_exp && field_r != F_IDLE && field_nxt == field_r && !store) begin
      field_nxt = F_IDLE;
      bad       = 1'b1;
    end
  end

  // screen, field and pending value
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scr_r   <= SCR_STAT;
      field_r <= F_IDLE;
      pend_r  <= 8'h00;
    end else begin
      scr_r   <= scr_nxt;
      field_r <= field_nxt;
      pend_r  <= pend_nxt;
    end
  end

  // local and remote mode
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remote_r <= 1'b0;
    end else begin
      remote_r <= rem_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // stored remote-link settings
  // ----------------------------------------------------------------------
  assign h_ok = remote_r && addr_ok(pwdata[`FP_SET_ADDR +: 8], gpib)
             && pwdata[`FP_SET_BAUD +: 3] <= `FP_BAUD_LAST
             && pwdata[`FP_SET_PAR +: 2] <= `FP_PAR_LAST;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_r <= `FP_RST_ADDR;
      baud_r <= `FP_RST_BAUD;
      par_r  <= `FP_RST_PAR;
      bus_r  <= 1'b0;
      srq_r  <= 1'b0;
      hrej_r <= 1'b0;
    end else if (h_set) begin
      hrej_r <= !h_ok;
      if (h_ok) begin
        addr_r <= pwdata[`FP_SET_ADDR +: 8];
        baud_r <= pwdata[`FP_SET_BAUD +: 3];
        par_r  <= pwdata[`FP_SET_PAR +: 2];
        bus_r  <= pwdata[`FP_SET_BUS];
        srq_r  <= pwdata[`FP_SET_SRQ];
      end
    end else if (store) begin
      case (field_r)
        F_BUS: begin
          if (gpib) begin
            srq_r <= pend_r[0];
          end else begin
            bus_r <= pend_r[0];
          end
        end
        F_ADDR:  addr_r <= pend_r;
        F_BAUD:  baud_r <= pend_r[2:0];
        F_PAR:   par_r  <= pend_r[1:0];
        default: addr_r <= addr_r;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // timers, screen saver and sounder
  // ----------------------------------------------------------------------
  // blanking needs both receivers active and no channel left in manual
  assign saver_ok = (&rcvr_active_i) && !(|chan_manual_i);

  fp_idle_timer #(.LIMIT(ENTRY_T)) u_entry (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (tick_r),
    .restart_i (restart_e || field_nxt != field_r),
    .run_i     (field_r != F_IDLE),
    .done_o    (ent_exp)
  );

  fp_idle_timer #(.LIMIT(IDLE_T)) u_idle (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (tick_r),
    .restart_i (key_press_i || !saver_ok),
    .run_i     (!saver_r),
    .done_o    (idle_exp)
  );

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      saver_r <= 1'b0;
    end else if (wake || !saver_ok) begin
      saver_r <= 1'b0;
    end else if (idle_exp) begin
      saver_r <= 1'b1;
    end
  end

  // every key acknowledges; on an illegal one the error tone takes the place of the beep
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      ack_r <= key_press_i;
      err_r <= bad;
    end
  end

  fp_tone #(.ACK_T(`FP_BEEP_MS), .ERR_T(`FP_ERR_MS)) u_tone (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .tick_i     (tick_r),
    .ack_i      (ack_r),
    .err_i      (err_r),
    .beep_o     (beep_o),
    .err_tone_o (err_tone_o)
  );

  // indicators
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_r <= 1'b0;
      limit_r <= 1'b0;
    end else begin
      alarm_r <= |hw_fault_i;
      limit_r <= |chan_limit_i;
    end
  end

  // ----------------------------------------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------------------------------------
  assign apb_su = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign h_set  = apb_wr && paddr == `FP_REG_SET;
  assign h_rem  = apb_wr && paddr == `FP_REG_CTRL && pwdata[`FP_CT_GOREM];
  assign h_loc  = apb_wr && paddr == `FP_REG_CTRL && pwdata[`FP_CT_GOLOC];
  assign rd_ok  = paddr == `FP_REG_STAT || paddr == `FP_REG_SET
               || paddr == `FP_REG_CTRL;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rd_ok;

  always_comb begin
    stat_w = 32'h0000_0000;
    stat_w[`FP_ST_REMOTE] = remote_r;
    stat_w[`FP_ST_SAVER]  = saver_r;
    stat_w[`FP_ST_EDIT]   = (field_r != F_IDLE);
    stat_w[`FP_ST_ALARM]  = alarm_r;
    stat_w[`FP_ST_LIMIT]  = limit_r;
    stat_w[`FP_ST_HREJ]   = hrej_r;
    stat_w[`FP_ST_BUILD +: 2] = bus_build_i;
    set_w = 32'h0000_0000;
    set_w[`FP_SET_ADDR +: 8] = addr_r;
    set_w[`FP_SET_BAUD +: 3] = baud_r;
    set_w[`FP_SET_PAR +: 2]  = par_r;
    set_w[`FP_SET_BUS]       = bus_r;
    set_w[`FP_SET_SRQ]       = srq_r;
    // status reads are answered in either mode
    case (paddr)
      `FP_REG_STAT: rd_w = stat_w;
      `FP_REG_SET:  rd_w = set_w;
      default:      rd_w = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup cycle, valid through the access cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata <= 32'h0000_0000;
    end else if (apb_su) begin
      prdata <= rd_w;
    end
  end

  assign screen_o      = scr_r;
  assign saver_o       = saver_r;
  assign remote_led_o  = remote_r;
  assign alarm_led_o   = alarm_r;
  assign correction_limit_indicator_o = limit_r;
  assign remote_addr_o = addr_r;
  assign baud_sel_o    = baud_r;
  assign parity_o      = par_r;
  assign bus_sel_o     = bus_r;
  assign srq_en_o      = srq_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_rem_toggle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    act && !gpib && key_code_i == `FP_KEY_REMOTE && !apb_wr |=> remote_led_o != $past(remote_r))
    else $error("remote key did not toggle mode");
  chk_gpib_local: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    act && gpib && key_code_i == `FP_KEY_REMOTE && !h_rem |=> !remote_led_o)
    else $error("remote key did not force local");
  chk_rs232_bus: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    act && rs232 && scr_r == SCR_RSUB && key_code_i == 4'h6 |=> err_r && $stable(bus_r))
    else $error("bus key accepted on serial-232 build");
  chk_host_local: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    h_set && !remote_r |=> $stable(addr_r) && $stable(baud_r) && $stable(par_r))
    else $error("host changed settings in local mode");
  chk_panel_remote: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    act && remote_r && key_code_i == `FP_KEY_COMMIT |=> err_r ##1 err_tone_o)
    else $error("panel commit not refused in remote mode");
  chk_addr_range: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    act && !remote_r && key_code_i == `FP_KEY_COMMIT && field_r == F_ADDR
    && !addr_ok(pend_r, gpib) |=> err_r && $stable(addr_r))
    else $error("out of range address stored");
  chk_saver_inhibit: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !saver_ok |=> !saver_o)
    else $error("display blanked with setup incomplete");
  chk_saver_wake: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    saver_r && key_press_i |=> !saver_o && !idle_exp)
    else $error("key did not restore display");
  chk_entry_tmo: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ent_exp && field_r != F_IDLE && !key_press_i && !knob_step_i
    |=> field_r == F_IDLE && err_r)
    else $error("expired entry not abandoned");
  chk_key_ack: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    key_press_i |=> ack_r ##1 (beep_o || err_tone_o))
    else $error("key press without acknowledge");
endmodule : front_panel_remote_control

// *** fp_keypad_model.sv ***
`timescale 1ns/10ps
// keypad model: one press per request, code shown only with the press
module fp_keypad_model (
  // clock
  input  wire logic       mclk_i,
  // request from the bench
  input  wire logic       req_i,
  input  wire logic [3:0] code_i,
  // keypad lines
  output logic            key_press_o,
  output logic [3:0]      key_code_o
);
  // code flips while idle so the design cannot lean on a stale value
  always_ff @(posedge mclk_i) begin
    key_press_o <= req_i;
    key_code_o  <= req_i ? code_i : ~key_code_o;
  end
endmodule : fp_keypad_model

// *** front_panel_remote_control_bench.sv ***
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module front_panel_remote_control_bench;
  import fp_pkg::*;
  localparam int TC = 4, IT = 20, ET = 10;
  logic mclk_i, rst_n_i, key_press_i, knob_step_i, knob_up_i, psel, penable, pwrite, req;
  logic pready, pslverr, saver_o, remote_led_o, alarm_led_o, beep_o, err_tone_o, e;
  logic correction_limit_indicator_o, bus_sel_o, srq_en_o;
  logic [3:0] key_code_i, key_digit_i, hw_fault_i, code;
  logic [4:0] soft_map_i;
  logic [1:0] rcvr_active_i, parity_o;
  logic [9:0] chan_manual_i, chan_limit_i;
  logic [7:0] paddr, remote_addr_o;
  logic [31:0] pwdata, prdata, r;
  logic [2:0] baud_sel_o;
  build_t bus_build_i;
  screen_t screen_o;
  int bad_count, n_compared, cyc;
  // code in the top nibble, expected screen below it
  logic [9:0] rows [5] = '{10'h001, 10'h042, 10'h084, 10'h0C8, 10'h110};
  fp_keypad_model kp (.mclk_i(mclk_i), .req_i(req), .code_i(code),
    .key_press_o(key_press_i), .key_code_o(key_code_i));
  front_panel_remote_control #(.TICK_CYC(TC), .IDLE_T(IT), .ENTRY_T(ET)) uut (.*);
  // clock, and a ceiling so a hang still ends in the report
  initial begin
    mclk_i = 0;
    forever #10 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task key(input logic [3:0] c);
    @(posedge mclk_i) begin req <= 1; code <= c; end
    @(posedge mclk_i) req <= 0;
    repeat (4) @(posedge mclk_i);
  endtask : key
  task knob(input logic up);
    @(posedge mclk_i) begin knob_step_i <= 1; knob_up_i <= up; end
    @(posedge mclk_i) knob_step_i <= 0;
    repeat (3) @(posedge mclk_i);
  endtask : knob
  // mid-run reset, with the fitted bus swapped while it is held
  task rst(input build_t b);
    rst_n_i <= 0;
    bus_build_i <= b;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1;
    @(posedge mclk_i);
  endtask : rst
  // request held until pready is seen high at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i) begin psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; end
    @(posedge mclk_i) penable <= 1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    repeat (2) @(posedge mclk_i);
  endtask : apb
  initial begin
    {rst_n_i, req, code, knob_step_i, knob_up_i, psel, penable, pwrite, paddr, pwdata} = '0;
    {key_digit_i, hw_fault_i, chan_manual_i, chan_limit_i} = '0;
    bus_build_i = BUILD_SERIAL;
    soft_map_i = 5'h1F;
    rcvr_active_i = 2'b01;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1;
    @(posedge mclk_i);
    `CHK("screen", SCR_STAT, screen_o)
    `CHK("addr", 8'h40, remote_addr_o)
    for (int i = 0; i < 5; i++) begin
      key(rows[i][9:6]);
      `CHK("screen", rows[i][5:0], screen_o)
    end
    `CHK("beep", 1'b1, beep_o)
    key(4'h9);
    `CHK("screen", SCR_RSUB, screen_o)
    key(4'h7);
    knob(1);
    `CHK("addr", 8'h40, remote_addr_o)
    key(4'hA);
    `CHK("addr", 8'h41, remote_addr_o)
    // step below the serial floor, commit must be refused
    key(4'h7);
    knob(0);
    knob(0);
    key(4'hA);
    `CHK("addr", 8'h41, remote_addr_o)
    `CHK("err", 1'b1, err_tone_o)
    key(4'h7);
    knob(1);
    repeat (ET * TC + 20) @(posedge mclk_i);
    key(4'hA);
    `CHK("addr", 8'h41, remote_addr_o)
    // bus, baud and parity edits on the serial build, with wrap-around
    key(4'h6);
    knob(1);
    key(4'hA);
    `CHK("bus", 1'b1, bus_sel_o)
    key(4'h8);
    knob(1);
    knob(1);
    key(4'hA);
    `CHK("baud", 3'h0, baud_sel_o)
    key(4'h9);
    knob(1);
    knob(1);
    key(4'hA);
    `CHK("parity", 2'h1, parity_o)
    apb(1, 8'h04, 32'h0000_2550);
    `CHK("addr", 8'h41, remote_addr_o)
    apb(0, 8'h00, 32'h0000_0000);
    `CHK("rej", 1'b1, r[5])
    apb(1, 8'h08, 32'h0000_0001);
    `CHK("led", 1'b1, remote_led_o)
    apb(1, 8'h04, 32'h0000_2550);
    `CHK("addr", 8'h50, remote_addr_o)
    key(4'h7);
    knob(1);
    key(4'hA);
    `CHK("addr", 8'h50, remote_addr_o)
    key(4'hD);
    `CHK("led", 1'b0, remote_led_o)
    apb(0, 8'h0C, 32'h0000_0000);
    `CHK("slverr", 1'b1, e)
    hw_fault_i <= 4'h1;
    chan_limit_i <= 10'h200;
    repeat (3) @(posedge mclk_i);
    `CHK("alarm", 1'b1, alarm_led_o)
    `CHK("limit", 1'b1, correction_limit_indicator_o)
    repeat (IT * TC + 40) @(posedge mclk_i);
    `CHK("saver", 1'b0, saver_o)
    rcvr_active_i <= 2'b11;
    repeat (IT * TC + 40) @(posedge mclk_i);
    `CHK("saver", 1'b1, saver_o)
    key(4'h1);
    `CHK("saver", 1'b0, saver_o)
    // each reset below clears a running error tone so the next one is seen
    rcvr_active_i <= 2'b01;
    soft_map_i <= 5'h1E;
    rst(BUILD_SERIAL);
    `CHK("addr", 8'h40, remote_addr_o)
    `CHK("tone", 1'b0, err_tone_o)
    key(4'h5);
    `CHK("err", 1'b1, err_tone_o)
    `CHK("screen", SCR_STAT, screen_o)
    rst(BUILD_RS232);
    key(4'h4);
    key(4'h9);
    key(4'h6);
    `CHK("err", 1'b1, err_tone_o)
    knob(1);
    key(4'hA);
    `CHK("bus", 1'b0, bus_sel_o)
    rst(BUILD_GPIB);
    key(4'h4);
    key(4'h9);
    key(4'h6);
    key(4'hA);
    `CHK("srq", 1'b1, srq_en_o)
    `CHK("bus", 1'b0, bus_sel_o)
    key(4'h7);
    knob(0);
    key(4'hA);
    `CHK("addr", 8'h40, remote_addr_o)
    `CHK("err", 1'b1, err_tone_o)
    apb(1, 8'h08, 32'h0000_0001);
    `CHK("led", 1'b1, remote_led_o)
    key(4'hD);
    `CHK("led", 1'b0, remote_led_o)
    tally_and_finish();
  end
endmodule : front_panel_remote_control_bench
